// [logic/hptr_pkg.sv]
// Package for the hub port tuning register bank.
// Assumes a 10 MHz clock and an AXI4-Lite master with 32-bit data.
package hptr_pkg;
    localparam int ADDR_W = 17;
    localparam int IDX_W = 15;
    localparam int DATA_W = 32;
    localparam int SEL_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_GANG_EN = 15'h525A;
    localparam logic [IDX_W-1:0] IDX_GANG_SRC = 15'h525B;
    localparam logic [IDX_W-1:0] IDX_UP_DRIVE = 15'h60CA;
    localparam logic [IDX_W-1:0] IDX_UP_SQUELCH = 15'h60CC;
    localparam logic [IDX_W-1:0] IDX_UP_LINK = 15'h61C0;
    localparam logic [IDX_W-1:0] IDX_P1_DRIVE = 15'h64CA;
    localparam logic [IDX_W-1:0] IDX_P1_SQUELCH = 15'h64CC;

    // Field positions
    localparam int GANG_P1_BIT = 1;
    localparam int GANG_P2_BIT = 2;
    localparam int TRIM_W = 3;
    localparam int LINK_STATE_LSB = 4;

    // Reset values
    localparam logic [7:0] RST_GANG_EN = 8'h00;
    localparam logic [7:0] RST_GANG_SRC = 8'h00;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [TRIM_W-1:0] RST_SQUELCH = 3'h0;

    // Valid shared pin selector codes
    localparam logic [SEL_W-1:0] SEL_TEST_RESET = 6'h00;
    localparam logic [SEL_W-1:0] SEL_OC_IN_1 = 6'h01;
    localparam logic [SEL_W-1:0] SEL_OC_IN_2 = 6'h03;
    localparam logic [SEL_W-1:0] SEL_FLASH_CLK = 6'h04;
    localparam logic [SEL_W-1:0] SEL_FLASH_DO = 6'h05;
    localparam logic [SEL_W-1:0] SEL_OC_IN_3 = 6'h06;
    localparam logic [SEL_W-1:0] SEL_OC_IN_4 = 6'h07;
    localparam logic [SEL_W-1:0] SEL_PWR_CTL_1 = 6'h08;
    localparam logic [SEL_W-1:0] SEL_PWR_CTL_2 = 6'h09;
    localparam logic [SEL_W-1:0] SEL_PWR_CTL_3 = 6'h0A;
    localparam logic [SEL_W-1:0] SEL_MGMT_CLK = 6'h0F;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] state;
        logic [2:0] sub_state;
    } hptr_link_type;

    typedef struct packed {
        logic [TRIM_W-1:0] up_drive;
        logic [TRIM_W-1:0] up_squelch;
        logic [TRIM_W-1:0] p1_drive;
        logic [TRIM_W-1:0] p1_squelch;
    } hptr_trim_type;

    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP = 1'b1
    } hptr_wr_state_type;
endpackage

// [logic/hptr_regs.sv]
// Hub port tuning register bank with AXI4-Lite slave.
// Assumes inputs synchronous to i_clk; link state comes from the SS PHY.
// Behaviour
// - Setting gang bit 1 or 2 makes port 1 or 2 take its overcurrent status from the shared selected pin.
// - The six-bit shared pin selector in bits 5:0 stores any code, but only codes 0,1,3-10 and 15 select a pin; software avoids others.
// - The drive trim is a three-bit read/write field in bits 2:0 with 000 meaning nominal current.
// - The squelch trim is a three-bit read/write field in bits 2:0, nominal at 000, with bits 7:3 read-only.
// - The upstream link report is read-only, state in bits 7:4 and sub-state in bits 2:0, bit 3 reserved.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module hptr_regs
    import hptr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [DATA_W-1:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [ADDR_W-1:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [DATA_W-1:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    input wire logic [15:0] i_shared_pins,
    input wire logic [2:1] i_port_oc_own,
    input wire hptr_link_type i_up_link,
    output logic [2:1] o_port_oc,
    output hptr_trim_type o_trim
);
    logic [1:0] rst_sync_reg;
    logic rst_n;

    hptr_wr_state_type wr_state_reg, wr_state_next;
    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [IDX_W-1:0] waddr_reg, waddr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wstrb_reg, wstrb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;

    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;

    logic [7:0] gang_en_reg, gang_en_next;
    logic [7:0] gang_src_reg, gang_src_next;
    logic [7:0] up_drive_reg, up_drive_next;
    logic [7:0] p1_drive_reg, p1_drive_next;
    logic [TRIM_W-1:0] up_sq_reg, up_sq_next;
    logic [TRIM_W-1:0] p1_sq_reg, p1_sq_next;
    hptr_link_type link_reg, link_next;
    logic [2:1] oc_reg, oc_next;
    logic shared_level;

    // Reset release through two flops
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Selector decode; unlisted codes give a quiet pin
    function automatic logic sel_valid(input logic [SEL_W-1:0] code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            SEL_TEST_RESET, SEL_OC_IN_1, SEL_OC_IN_2, SEL_FLASH_CLK,
            SEL_FLASH_DO, SEL_OC_IN_3, SEL_OC_IN_4, SEL_PWR_CTL_1,
            SEL_PWR_CTL_2, SEL_PWR_CTL_3, SEL_MGMT_CLK: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Readback of one register index
    function automatic logic [DATA_W+1:0] read_word(
        input logic [IDX_W-1:0] idx
    );
        logic [DATA_W+1:0] r;
        r = {RESP_OKAY, 32'h0000_0000};
        unique case (idx)
            IDX_GANG_EN: r[7:0] = gang_en_reg;
            IDX_GANG_SRC: r[7:0] = gang_src_reg;
            IDX_UP_DRIVE: r[7:0] = up_drive_reg;
            IDX_P1_DRIVE: r[7:0] = p1_drive_reg;
            IDX_UP_SQUELCH: r[TRIM_W-1:0] = up_sq_reg;
            IDX_P1_SQUELCH: r[TRIM_W-1:0] = p1_sq_reg;
            IDX_UP_LINK: r[7:0] = {link_reg.state, 1'b0,
                link_reg.sub_state};
            default: r[DATA_W+1:DATA_W] = RESP_SLVERR;
        endcase
        return r;
    endfunction

    // Write channel and register updates
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        gang_en_next = gang_en_reg;
        gang_src_next = gang_src_reg;
        up_drive_next = up_drive_reg;
        p1_drive_next = p1_drive_reg;
        up_sq_next = up_sq_reg;
        p1_sq_next = p1_sq_reg;
        unique case (wr_state_reg)
            WR_COLLECT: begin
                if (awready_reg && i_axi_awvalid) begin
                    aw_have_next = 1'b1;
                    waddr_next = i_axi_awaddr[ADDR_W-1:2];
                end
                if (wready_reg && i_axi_wvalid) begin
                    w_have_next = 1'b1;
                    wdata_next = i_axi_wdata[7:0];
                    wstrb_next = i_axi_wstrb[0];
                end
                if (aw_have_reg && w_have_reg) begin
                    aw_have_next = 1'b0;
                    w_have_next = 1'b0;
                    bvalid_next = 1'b1;
                    bresp_next = RESP_OKAY;
                    wr_state_next = WR_RESP;
                    unique case (waddr_reg)
                        IDX_GANG_EN: begin
                            if (wstrb_reg) begin
                                gang_en_next = wdata_reg;
                            end
                        end
                        IDX_GANG_SRC: begin
                            if (wstrb_reg) begin
                                gang_src_next = wdata_reg;
                            end
                        end
                        IDX_UP_DRIVE: begin
                            if (wstrb_reg) begin
                                up_drive_next = wdata_reg;
                            end
                        end
                        IDX_P1_DRIVE: begin
                            if (wstrb_reg) begin
                                p1_drive_next = wdata_reg;
                            end
                        end
                        IDX_UP_SQUELCH: begin
                            if (wstrb_reg) begin
                                up_sq_next = wdata_reg[TRIM_W-1:0];
                            end
                        end
                        IDX_P1_SQUELCH: begin
                            if (wstrb_reg) begin
                                p1_sq_next = wdata_reg[TRIM_W-1:0];
                            end
                        end
                        IDX_UP_LINK: bresp_next = RESP_OKAY;
                        default: bresp_next = RESP_SLVERR;
                    endcase
                end
            end
            WR_RESP: begin
                if (i_axi_bready) begin
                    bvalid_next = 1'b0;
                    wr_state_next = WR_COLLECT;
                end
            end
        endcase
        awready_next = (wr_state_next == WR_COLLECT) && !aw_have_next;
        wready_next = (wr_state_next == WR_COLLECT) && !w_have_next;
    end

    // Write state and register flops
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_reg <= WR_COLLECT;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= 8'h00;
            wstrb_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            gang_en_reg <= RST_GANG_EN;
            gang_src_reg <= RST_GANG_SRC;
            up_drive_reg <= RST_DRIVE;
            p1_drive_reg <= RST_DRIVE;
            up_sq_reg <= RST_SQUELCH;
            p1_sq_reg <= RST_SQUELCH;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            gang_en_reg <= gang_en_next;
            gang_src_reg <= gang_src_next;
            up_drive_reg <= up_drive_next;
            p1_drive_reg <= p1_drive_next;
            up_sq_reg <= up_sq_next;
            p1_sq_reg <= p1_sq_next;
        end
    end

    // Read channel
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && i_axi_rready) begin
            rvalid_next = 1'b0;
        end else if (arready_reg && i_axi_arvalid) begin
            rvalid_next = 1'b1;
            {rresp_next, rdata_next} = read_word(i_axi_araddr[ADDR_W-1:2]);
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // Shared overcurrent pin and per-port source choice
    assign shared_level = sel_valid(gang_src_reg[SEL_W-1:0]) &&
        i_shared_pins[gang_src_reg[3:0]];

    generate
        for (genvar p = 1; p <= 2; p++) begin : g_port
            localparam int GBIT = (p == 1) ? GANG_P1_BIT : GANG_P2_BIT;
            always_comb begin
                oc_next[p] = gang_en_reg[GBIT] ? shared_level :
                    i_port_oc_own[p];
            end
        end
    endgenerate

    // Link report sampled every clock
    always_comb begin
        link_next = i_up_link;
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_reg <= 2'h0;
            link_reg <= '0;
        end else begin
            oc_reg <= oc_next;
            link_reg <= link_next;
        end
    end

    // Bus and pin outputs
    assign o_axi_awready = awready_reg;
    assign o_axi_wready = wready_reg;
    assign o_axi_bvalid = bvalid_reg;
    assign o_axi_bresp = bresp_reg;
    assign o_axi_arready = arready_reg;
    assign o_axi_rvalid = rvalid_reg;
    assign o_axi_rresp = rresp_reg;
    assign o_axi_rdata = rdata_reg;
    assign o_port_oc = oc_reg;
    assign o_trim = '{up_drive: up_drive_reg[TRIM_W-1:0],
        up_squelch: up_sq_reg, p1_drive: p1_drive_reg[TRIM_W-1:0],
        p1_squelch: p1_sq_reg};
endmodule
`default_nettype wire

// [tb/hptr_regs_checker.sv]
// Assertions on the ports of the hub port tuning register bank.
// Assumes it is bound to hptr_regs and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module hptr_regs_checker
    import hptr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    input wire logic o_axi_arready,
    input wire logic [DATA_W-1:0] o_axi_rdata,
    input wire logic o_axi_rvalid,
    input wire logic i_axi_rready,
    input wire logic o_axi_bvalid,
    input wire logic [1:0] o_axi_bresp,
    input wire logic i_axi_bready,
    input wire logic [15:0] i_shared_pins,
    input wire logic [2:1] i_port_oc_own,
    input wire logic [2:1] o_port_oc,
    input wire hptr_trim_type o_trim
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [IDX_W-1:0] ridx;
    logic ar_take;
    assign ridx = i_axi_araddr[ADDR_W-1:2];
    assign ar_take = i_axi_arvalid && o_axi_arready;
    a_oc_quiet: assert property (
        (i_shared_pins == 16'h0000 && i_port_oc_own == 2'h0)
        |=> o_port_oc == 2'h0) else $error("overcurrent with sources low");
    a_trim_on_write: assert property (
        $changed(o_trim) |-> $rose(o_axi_bvalid))
        else $error("trim changed without a write");
    a_squelch_rsvd: assert property (
        ar_take && (ridx == IDX_UP_SQUELCH || ridx == IDX_P1_SQUELCH)
        |=> o_axi_rdata[7:3] == 5'h00) else $error("squelch reserved set");
    a_link_rsvd: assert property (
        ar_take && ridx == IDX_UP_LINK |=> o_axi_rvalid && !o_axi_rdata[3])
        else $error("link reserved bit set");
    a_read_answer: assert property (
        ar_take |=> o_axi_rvalid) else $error("read not answered");
    a_rdata_upper: assert property (
        o_axi_rvalid |-> o_axi_rdata[31:8] == 24'h000000)
        else $error("upper read data set");
    a_rvalid_hold: assert property (
        o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
        else $error("read data dropped");
    a_bvalid_hold: assert property (
        o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
        else $error("write response dropped");
endmodule
bind hptr_regs hptr_regs_checker u_chk (.i_clk, .i_rstn, .i_axi_araddr,
    .i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rvalid, .i_axi_rready,
    .o_axi_bvalid, .o_axi_bresp, .i_axi_bready, .i_shared_pins, .i_port_oc_own,
    .o_port_oc, .o_trim);
`default_nettype wire

// [tb/hptr_regs_tb.sv]
// Self-checking bench for the hub port tuning register bank.
// Assumes the checker is bound in beside the design.
`timescale 1ns/10ps
`default_nettype none
module hptr_regs_tb
    import hptr_pkg::*;
;
    logic clk, rstn, awv, wv, bry, arv, rry, awr, wr_rdy, bv, arr, rv;
    logic [ADDR_W-1:0] awa, ara;
    logic [31:0] wd, rd;
    logic [3:0] ws;
    logic [1:0] br, rr;
    logic [15:0] pins;
    logic [2:1] own, oc;
    hptr_link_type link;
    hptr_trim_type trim;
    logic [7:0] mdl [7];
    logic [14:0] idx [7];
    int errors, total_checks;

    hptr_regs u_dut (.i_clk(clk), .i_rstn(rstn), .i_axi_awaddr(awa),
        .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wd),
        .i_axi_wstrb(ws), .i_axi_wvalid(wv), .o_axi_wready(wr_rdy),
        .o_axi_bresp(br), .o_axi_bvalid(bv), .i_axi_bready(bry),
        .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr),
        .o_axi_rdata(rd), .o_axi_rresp(rr), .o_axi_rvalid(rv),
        .i_axi_rready(rry), .i_shared_pins(pins), .i_port_oc_own(own),
        .i_up_link(link), .o_port_oc(oc), .o_trim(trim));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic axw(input logic [14:0] i, input logic [31:0] d,
        input logic [3:0] st, input logic [1:0] er);
        bit b;
        b = 0;
        @(posedge clk);
        awa <= {i, 2'b00};
        wd <= d;
        ws <= st;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
            if (bv) begin
                bry <= 1'b0;
                b = 1;
                chk("bresp", 32'(br), 32'(er));
            end
        end
        if (!b) chk("bvalid", 32'(bv), 32'h1);
    endtask

    task automatic axr(input logic [14:0] i, input logic [31:0] e,
        input logic [1:0] er);
        bit b;
        b = 0;
        @(posedge clk);
        ara <= {i, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin
                rry <= 1'b0;
                b = 1;
                chk("rdata", rd, e);
                chk("rresp", 32'(rr), 32'(er));
            end
        end
        if (!b) chk("rvalid", 32'(rv), 32'h1);
    endtask

    function automatic logic [31:0] exp_rd(int k);
        if (k == 4) return {24'h0, link.state, 1'b0, link.sub_state};
        return {24'h0, mdl[k]};
    endfunction

    function automatic logic [2:1] exp_oc();
        logic [5:0] s;
        logic g;
        s = mdl[1][5:0];
        g = (s inside {[0:1], [3:10], 15}) ? pins[s[3:0]] : 1'b0;
        return {mdl[0][2] ? g : own[2], mdl[0][1] ? g : own[1]};
    endfunction

    task automatic wr(input int k, input logic [31:0] d, input logic [3:0] st);
        logic [7:0] m;
        m = (k == 3 || k == 6) ? 8'h07 : (k == 4) ? 8'h00 : 8'hFF;
        if (k == 1 && !(d[5:0] inside {[0:1], [3:10], 15})) begin
            d[5:0] = 6'h0F;
        end
        axw(idx[k], d, st, RESP_OKAY);
        if (st[0]) mdl[k] = (d[7:0] & m) | (mdl[k] & ~m);
        chk("trim", 32'(trim), 32'({mdl[2][2:0], mdl[3][2:0], mdl[5][2:0],
            mdl[6][2:0]}));
        axr(idx[k], exp_rd(k), RESP_OKAY);
    endtask

    initial begin
        void'($urandom(32'h7B7A));
        {rstn, awv, wv, bry, arv, rry, awa, ara, wd, ws} = '0;
        {pins, own, link} = '0;
        mdl = '{default: 8'h00};
        idx = '{IDX_GANG_EN, IDX_GANG_SRC, IDX_UP_DRIVE, IDX_UP_SQUELCH,
            IDX_UP_LINK, IDX_P1_DRIVE, IDX_P1_SQUELCH};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            axr(idx[k], exp_rd(k), RESP_OKAY);
        end
        $display("test reset values done");
        for (int k = 0; k < 7; k++) begin
            wr(k, 32'hFFFFFFFF, 4'hF);
        end
        repeat (40) wr($urandom_range(6), $urandom, 4'($urandom));
        $display("test register access done");
        axw(15'h0001, 32'h000000FF, 4'hF, RESP_SLVERR);
        axr(15'h0001, 32'h0, RESP_SLVERR);
        for (int k = 0; k < 7; k++) begin
            axr(idx[k], exp_rd(k), RESP_OKAY);
        end
        $display("test unmapped done");
        repeat (6) begin
            @(posedge clk);
            link <= hptr_link_type'(7'($urandom));
            repeat (3) @(posedge clk);
            wr(4, $urandom, 4'hF);
        end
        $display("test link report done");
        for (int c = 0; c < 17; c++) begin
            wr(1, 32'(c) | ($urandom & 32'hC0), 4'h1);
            wr(0, $urandom, 4'h1);
            for (int k = 0; k < 3; k++) begin
                @(posedge clk);
                pins <= (k == 0) ? 16'h0000 : 16'($urandom);
                own <= (k == 0) ? 2'h0 : 2'($urandom);
                repeat (3) @(posedge clk);
                chk("port_oc", 32'(oc), 32'(exp_oc()));
            end
        end
        $display("test overcurrent gang done");
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
